/* bench/cms_cfg_src.sv */
// behavioural configuration source strobing data units into the block
module cms_cfg_src (
    input  logic       aclk,
    input  logic       go,
    input  logic       slow,
    input  logic [7:0] units,
    output logic       busy = 1'b0,
    output logic       cfg_strobe = 1'b0,
    output logic [7:0] cfg_data = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_ff = 8'h00;
    logic [3:0] ph_ff = 4'h0;
    always @(posedge aclk) begin
        if (!busy) begin
            cfg_strobe <= 1'b0;
            // released bus: inverts every cycle, so it shows the last unit every other cycle
            cfg_data <= ~cfg_data;
            if (go && units != 8'h00) begin
                busy <= 1'b1;
                left_ff <= units;
                ph_ff <= 4'h0;
            end
        end else begin
            ph_ff <= ph_ff + 4'h1;
            if (ph_ff == 4'h0) begin
                cfg_strobe <= 1'b1;
                cfg_data <= left_ff;
            end else if (ph_ff == 4'h3) begin
                cfg_strobe <= 1'b0;
            end else if (ph_ff == (slow ? 4'h9 : 4'h5)) begin
                ph_ff <= 4'h0;
                left_ff <= left_ff - 8'h1;
                busy <= (left_ff != 8'h1);
            end
        end
    end
endmodule // cms_cfg_src

/* bench/cms_props.sv */
// assertion checker for the mode sequencer pins, bound into cms_top
module cms_props #(
    parameter [21:0] POR_LONG_CYC  = 22'h28,
    parameter [21:0] POR_SHORT_CYC = 22'h8
) (
    input wire aclk,
    input wire aresetn,
    input wire por_delay_select,
    input wire pullup_disable,
    input wire reconfig_n,
    input wire chain_enable_out_n,
    input wire io_hiz,
    input wire io_pullup_en,
    input wire user_reset_n,
    input wire user_mode,
    input wire pll_shift_int,
    input wire pll_load_int
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // cycles since reset release; saturates so it never wraps to zero
    reg  [21:0] por_cnt_ff;
    wire [21:0] nxt_por_cnt = &por_cnt_ff ? por_cnt_ff : por_cnt_ff + 22'h1;
    always @(posedge aclk) begin
        if (!aresetn) por_cnt_ff <= 22'h0;
        else por_cnt_ff <= nxt_por_cnt;
    end

    sequence s_init_hold;
        !user_mode [*8];
    endsequence
    sequence s_user_up;
        !user_mode ##8 user_mode;
    endsequence

    property p_cmd;
        !user_mode |-> io_hiz && !user_reset_n;
    endproperty
    property p_user;
        user_mode |-> !io_hiz && user_reset_n && !io_pullup_en;
    endproperty
    property p_pullup;
        pullup_disable [*6] |-> !io_pullup_en;
    endproperty
    property p_reconfig;
        !reconfig_n [*7] |-> !user_mode;
    endproperty
    property p_init;
        $fell(chain_enable_out_n) |-> s_init_hold ##1 s_user_up;
    endproperty
    property p_chain;
        user_mode |-> !chain_enable_out_n;
    endproperty
    property p_por_long;
        $fell(chain_enable_out_n) && !por_delay_select
            |-> por_cnt_ff > POR_LONG_CYC;
    endproperty
    property p_por_short;
        $fell(chain_enable_out_n) |-> por_cnt_ff > POR_SHORT_CYC;
    endproperty
    property p_pll;
        reconfig_n [*4] ##0 (user_mode && (pll_shift_int || pll_load_int))
            |=> user_mode;
    endproperty

    a_cmd: assert property (p_cmd)
        else $error("i/o driven outside user mode");
    a_user: assert property (p_user)
        else $error("user mode without enabled i/o");
    a_pullup: assert property (p_pullup)
        else $error("pull-ups on while disabled");
    a_reconfig: assert property (p_reconfig)
        else $error("user mode kept under reconfig");
    a_init: assert property (p_init)
        else $error("init phase length wrong");
    a_chain: assert property (p_chain)
        else $error("chain output high in user mode");
    a_por_long: assert property (p_por_long)
        else $error("long power-on delay cut short");
    a_por_short: assert property (p_por_short)
        else $error("load before power-on delay");
    a_pll: assert property (p_pll)
        else $error("pll reload left user mode");
endmodule // cms_props

bind cms_top cms_props #(
    .POR_LONG_CYC (POR_LONG_CYC),
    .POR_SHORT_CYC(POR_SHORT_CYC)
) i_cms_props (
    .aclk(aclk), .aresetn(aresetn), .por_delay_select(por_delay_select),
    .pullup_disable(pullup_disable), .reconfig_n(reconfig_n),
    .chain_enable_out_n(chain_enable_out_n), .io_hiz(io_hiz),
    .io_pullup_en(io_pullup_en), .user_reset_n(user_reset_n),
    .user_mode(user_mode), .pll_shift_int(pll_shift_int),
    .pll_load_int(pll_load_int)
);

/* bench/tb_config_mode_sequencer.sv */
// self-checking bench for cms_top with a configuration source model
module tb_config_mode_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_LEN  = 12'h004;
    localparam logic [11:0] A_STAT = 12'h008;
    localparam logic [11:0] A_PLL  = 12'h00c;
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        por_delay_select = 0, pullup_disable = 0, reconfig_n = 1;
    logic        chain_enable_in_n = 1, pll_sdata_pin = 0, pll_sclk_pin = 0;
    logic        pll_load_pin = 0, pll_sdata_int = 0, pll_shift_int = 0;
    logic        pll_load_int = 0, src_go = 0, src_slow = 0;
    logic [7:0]  src_units = 8'h00;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire         s_axi_rvalid, chain_enable_out_n, io_hiz, io_pullup_en;
    wire         user_reset_n, user_mode, cfg_strobe, src_busy;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    wire [7:0]   cfg_data, pll_mult, pll_div, pll_delay;
    int          miscompares = 0, checked = 0, cyc = 0;

    cms_top #(.POR_LONG_CYC(22'h28), .POR_SHORT_CYC(22'h8)) i_cms_top (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .por_delay_select, .reconfig_n,
        .pullup_disable, .cfg_strobe, .chain_enable_in_n, .cfg_data,
        .chain_enable_out_n, .pll_load_pin, .pll_sdata_pin, .pll_sclk_pin,
        .pll_sdata_int, .pll_shift_int, .pll_load_int, .io_hiz, .user_mode,
        .io_pullup_en, .user_reset_n, .pll_mult, .pll_div, .pll_delay);
    cms_cfg_src i_cms_cfg_src (.aclk(aclk), .go(src_go), .slow(src_slow),
        .units(src_units), .busy(src_busy), .cfg_strobe(cfg_strobe),
        .cfg_data(cfg_data));

    always #12.5 aclk = ~aclk;
    always @(posedge aclk) cyc <= aresetn ? cyc + 1 : 0;

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        checked++;
        if (seen !== ex) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task wrap_up;
        if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task axi_wr(input logic [11:0] a, input logic [31:0] d,
                output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task axi_rd(input logic [11:0] a, output logic [31:0] d,
                output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task rst(input logic sel, input logic pud, input logic cin);
        @(posedge aclk);
        aresetn <= 1'b0;
        por_delay_select <= sel;
        pullup_disable <= pud;
        chain_enable_in_n <= cin;
        reconfig_n <= 1'b1;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task send(input logic [7:0] n, input logic slow);
        @(posedge aclk);
        src_go <= 1'b1;
        src_units <= n;
        src_slow <= slow;
        @(posedge aclk);
        src_go <= 1'b0;
        @(posedge aclk);
        while (src_busy) @(posedge aclk);
    endtask
    task wait_user;
        while (!user_mode) @(posedge aclk);
    endtask
    task regs;
        logic [31:0] d;
        logic [1:0]  r;
        rst(1'b1, 1'b0, 1'b1);
        axi_rd(A_CTRL, d, r);
        chk("ctrl reset", d, 32'h0000_0000);
        axi_rd(A_LEN, d, r);
        chk("length reset", d, 32'h0000_0010);
        axi_rd(A_PLL, d, r);
        chk("pll reset", d, 32'h0000_0101);
        axi_rd(12'h100, d, r);
        chk("unmapped resp", r, 2'h2);
        axi_wr(A_STAT, 32'hffff_ffff, r);
        chk("status write resp", r, 2'h2);
        axi_wr(A_CTRL, 32'h0000_000b, r);
        axi_rd(A_CTRL, d, r);
        chk("ctrl back", d, 32'h0000_000b);
    endtask
    // one full power-on, configuration and initialisation pass
    task boot(input logic sel, input logic pud, input logic [2:0] sch,
              input logic early);
        logic [31:0] st;
        logic [1:0]  r;
        logic [7:0]  n;
        n = (sch == 3'h2 || sch == 3'h3) ? 8'h02 : 8'h10;
        rst(sel, pud, !early);
        axi_wr(A_CTRL, {29'h0000_0000, sch}, r);
        axi_wr(A_LEN, 32'h0000_0002, r);
        chk("hiz at power-up", io_hiz, 1'b1);
        chk("pullups", io_pullup_en, !pud);
        chk("user reset held", user_reset_n, 1'b0);
        if (early) send(n, 1'b0);
        while (cyc < 20) @(posedge aclk);
        axi_rd(A_STAT, st, r);
        chk("por state", st[2:0], sel ? 3'h1 : 3'h0);
        chk("command flag", st[5], 1'b1);
        if (early) begin
            while (cyc < 60) @(posedge aclk);
            axi_rd(A_STAT, st, r);
            chk("early data ignored", st[2:0], 3'h2);
        end
        chain_enable_in_n <= 1'b0;
        send(n, sch == 3'h4);
        wait_user;
        chk("user mode", user_mode, 1'b1);
        chk("hiz in user", io_hiz, 1'b0);
        chk("user reset free", user_reset_n, 1'b1);
        chk("chain out", chain_enable_out_n, 1'b0);
        axi_rd(A_STAT, st, r);
        chk("user state", {st[5:4], st[2:0]}, 5'b0_1100);
    endtask
    task pll(input logic pins, input logic [23:0] v);
        logic [1:0] r;
        axi_wr(A_CTRL, {28'h000_0000, pins, 3'h2}, r);
        for (int i = 23; i >= 0; i--) begin
            @(posedge aclk);
            if (pins) begin
                pll_sdata_pin <= v[i];
                pll_sclk_pin <= 1'b0;
                repeat (3) @(posedge aclk);
                pll_sclk_pin <= 1'b1;
                repeat (2) @(posedge aclk);
            end else begin
                pll_sdata_int <= v[i];
                pll_shift_int <= 1'b1;
            end
        end
        @(posedge aclk);
        pll_shift_int <= 1'b0;
        pll_sclk_pin <= 1'b0;
        pll_load_int <= !pins;
        pll_load_pin <= pins;
        repeat (3) @(posedge aclk);
        pll_load_int <= 1'b0;
        pll_load_pin <= 1'b0;
        repeat (6) @(posedge aclk);
        chk("pll mult", pll_mult, v[23:16]);
        chk("pll div", pll_div, v[15:8]);
        chk("pll delay", pll_delay, v[7:0]);
        chk("user during pll", user_mode, 1'b1);
    endtask
    task reconfig;
        logic [31:0] st;
        logic [1:0]  r;
        reconfig_n <= 1'b0;
        repeat (8) @(posedge aclk);
        chk("forced command", user_mode, 1'b0);
        chk("hiz on reconfig", io_hiz, 1'b1);
        axi_rd(A_STAT, st, r);
        chk("reconfig count", st[15:8], 8'h01);
        reconfig_n <= 1'b1;
        repeat (4) @(posedge aclk);
        send(8'h02, 1'b1);
        wait_user;
        chk("user again", user_mode, 1'b1);
        chk("reinit reset", user_reset_n, 1'b1);
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        wrap_up;
    end
    initial begin
        regs;
        for (int s = 0; s < 5; s++) boot(1'b1, 1'b0, s[2:0], 1'b0);
        boot(1'b0, 1'b1, 3'h2, 1'b1);
        pll(1'b0, 24'ha5_3c81);
        pll(1'b1, 24'h5a_c318);
        reconfig;
        wrap_up;
    end
endmodule // tb_config_mode_sequencer

/* hdl/cms_pll_shift.v */
// serial reload chain for pll multiply, divide and delay counters
`include "cms_regs.vh"
module cms_pll_shift (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       shift_en,
    input  wire       sdata,
    input  wire       load,
    output reg  [7:0] pll_mult_ff,
    output reg  [7:0] pll_div_ff,
    output reg  [7:0] pll_delay_ff
);
    reg [`CMS_PLL_BITS-1:0] chain_ff;

    // chain shifts msb first; settings only change on load so the
    // running pll never sees a half-shifted value
    always @(posedge aclk) begin
        if (!aresetn) begin
            chain_ff     <= 24'h00_0000;
            pll_mult_ff  <= 8'h01;
            pll_div_ff   <= 8'h01;
            pll_delay_ff <= 8'h00;
        end else begin
            if (shift_en) begin
                chain_ff <= {chain_ff[`CMS_PLL_BITS-2:0], sdata};
            end
            if (load) begin
                pll_mult_ff  <= chain_ff[23:16];
                pll_div_ff   <= chain_ff[15:8];
                pll_delay_ff <= chain_ff[7:0];
            end
        end
    end
endmodule // cms_pll_shift

/* hdl/cms_regs.vh */
// register map, field positions and timing constants of the sequencer
`ifndef CMS_REGS_VH
`define CMS_REGS_VH

// ----------------------------------------------------------------
// register word addresses (byte address = index * 4)
// ----------------------------------------------------------------
`define CMS_REG_CTRL      2'h0
`define CMS_REG_CFG_LEN   2'h1
`define CMS_REG_STATUS    2'h2
`define CMS_REG_PLL       2'h3
`define CMS_ADDR_HI       11
`define CMS_ADDR_LO       2

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define CMS_CTRL_SCHEME   2:0
`define CMS_CTRL_PLL_PINS 3
`define CMS_CTRL_RST      32'h0000_0000
`define CMS_LEN_RST       16'h0010
`define CMS_SCHEME_CDEV   3'h0
`define CMS_SCHEME_PS     3'h1
`define CMS_SCHEME_PPA    3'h2
`define CMS_SCHEME_FPP    3'h3
`define CMS_SCHEME_JTAG   3'h4

// ----------------------------------------------------------------
// axi answers
// ----------------------------------------------------------------
`define CMS_RESP_OKAY     2'h0
`define CMS_RESP_SLVERR   2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CMS_CLK_KHZ       40000
`define CMS_POR_LONG_MS   100
`define CMS_POR_SHORT_MS  2
`define CMS_INIT_CYC      8'h10
`define CMS_PLL_BITS      24

`endif

/* hdl/cms_sync2.v */
// two-stage synchroniser for pins entering the clock domain
module cms_sync2 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [WIDTH-1:0] d,
    output wire [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= INIT;
            sync_ff <= INIT;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule // cms_sync2

/* hdl/cms_top.v */
// power-on, command-mode and user-mode sequencer with axi4-lite registers
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`include "cms_regs.vh"
module cms_top #(
    parameter [21:0] POR_LONG_CYC  = `CMS_POR_LONG_MS  * `CMS_CLK_KHZ,
    parameter [21:0] POR_SHORT_CYC = `CMS_POR_SHORT_MS * `CMS_CLK_KHZ
) (
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite slave
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // device pins
    input  wire        por_delay_select,
    input  wire        pullup_disable,
    input  wire        reconfig_n,
    input  wire        chain_enable_in_n,
    output reg         chain_enable_out_n,
    input  wire [7:0]  cfg_data,
    input  wire        cfg_strobe,
    input  wire        pll_sdata_pin,
    input  wire        pll_sclk_pin,
    input  wire        pll_load_pin,
    // user logic side
    input  wire        pll_sdata_int,
    input  wire        pll_shift_int,
    input  wire        pll_load_int,
    output reg         io_hiz,
    output reg         io_pullup_en,
    output reg         user_reset_n,
    output reg         user_mode,
    output wire [7:0]  pll_mult,
    output wire [7:0]  pll_div,
    output wire [7:0]  pll_delay
);
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [2:0] ST_POR  = 3'h0;
    localparam [2:0] ST_WAIT = 3'h1;
    localparam [2:0] ST_CFG  = 3'h2;
    localparam [2:0] ST_INIT = 3'h3;
    localparam [2:0] ST_USER = 3'h4;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    wire [7:0] cfg_data_s;
    wire       por_sel_s;
    wire       pullup_dis_s;
    wire       reconfig_n_s;
    wire       ce_in_n_s;
    wire       strobe_s;
    wire       pll_sd_s;
    wire       pll_sclk_s;
    wire       pll_ld_s;
    wire       unused_s;

    cms_sync2 #(.WIDTH(8), .INIT(8'h00)) u_sync_data (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (cfg_data),
        .q       (cfg_data_s)
    );
    cms_sync2 #(.WIDTH(9), .INIT(9'h060)) u_sync_ctl (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({por_delay_select, pullup_disable, reconfig_n,
                   chain_enable_in_n, cfg_strobe, pll_sdata_pin,
                   pll_sclk_pin, pll_load_pin, 1'b0}),
        .q       ({por_sel_s, pullup_dis_s, reconfig_n_s, ce_in_n_s,
                   strobe_s, pll_sd_s, pll_sclk_s, pll_ld_s,
                   unused_s})
    );

    // edge detection on synchronised strobes only
    reg strobe_d_ff;
    reg pll_sclk_d_ff;
    reg pll_ld_d_ff;
    wire strobe_rise = strobe_s & ~strobe_d_ff;
    wire sclk_rise   = pll_sclk_s & ~pll_sclk_d_ff;
    wire ld_rise     = pll_ld_s & ~pll_ld_d_ff;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [31:0] ctrl_ff;
    reg [15:0] cfg_len_ff;
    reg [2:0]  state_ff;
    reg [2:0]  nxt_state;
    reg [21:0] cnt_ff;
    reg [21:0] nxt_cnt;
    reg [18:0] bit_cnt_ff;
    reg [18:0] nxt_bit_cnt;
    reg        por_sel_ff;
    reg [7:0]  reconfig_cnt_ff;

    wire [2:0]  scheme    = ctrl_ff[`CMS_CTRL_SCHEME];
    wire        serial_in = (scheme == `CMS_SCHEME_CDEV) ||
                            (scheme == `CMS_SCHEME_PS) ||
                            (scheme == `CMS_SCHEME_JTAG);
    // one bit per strobe for serial schemes, a byte for parallel ones
    wire [18:0] bit_step  = serial_in ? 19'h0_0001 : 19'h0_0008;
    wire [18:0] bit_total = {cfg_len_ff, 3'h0};
    wire [21:0] por_limit = por_sel_ff ? POR_SHORT_CYC : POR_LONG_CYC;
    wire        forced    = ~reconfig_n_s & (state_ff != ST_POR);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always @* begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_bit_cnt = bit_cnt_ff;
        case (state_ff)
            ST_POR: begin
                if (cnt_ff >= por_limit - 22'h00_0001) begin
                    nxt_state = ST_WAIT;
                    nxt_cnt   = 22'h00_0000;
                end else begin
                    nxt_cnt = cnt_ff + 22'h00_0001;
                end
            end
            ST_WAIT: begin
                nxt_bit_cnt = 19'h0_0000;
                if (~ce_in_n_s && reconfig_n_s) begin
                    nxt_state = ST_CFG;
                end
            end
            ST_CFG: begin
                if (strobe_rise) begin
                    nxt_bit_cnt = bit_cnt_ff + bit_step;
                end
                if (bit_cnt_ff >= bit_total) begin
                    nxt_state = ST_INIT;
                    nxt_cnt   = 22'h00_0000;
                end
            end
            ST_INIT: begin
                if (cnt_ff[7:0] == `CMS_INIT_CYC - 8'h01) begin
                    nxt_state = ST_USER;
                end else begin
                    nxt_cnt = cnt_ff + 22'h00_0001;
                end
            end
            ST_USER: begin
                nxt_state = ST_USER;
            end
            default: begin
                nxt_state = ST_POR;
                nxt_cnt   = 22'h00_0000;
            end
        endcase
        if (forced) begin
            nxt_state = ST_WAIT;
            nxt_cnt   = 22'h00_0000;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_ff        <= ST_POR;
            cnt_ff          <= 22'h00_0000;
            bit_cnt_ff      <= 19'h0_0000;
            por_sel_ff      <= 1'b0;
            reconfig_cnt_ff <= 8'h00;
            strobe_d_ff     <= 1'b0;
            pll_sclk_d_ff   <= 1'b0;
            pll_ld_d_ff     <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            cnt_ff        <= nxt_cnt;
            bit_cnt_ff    <= nxt_bit_cnt;
            strobe_d_ff   <= strobe_s;
            pll_sclk_d_ff <= pll_sclk_s;
            pll_ld_d_ff   <= pll_ld_s;
            // strap is re-read each cycle of the delay; settles early
            if (state_ff == ST_POR) begin
                por_sel_ff <= por_sel_s;
            end
            if (forced && state_ff == ST_USER) begin
                reconfig_cnt_ff <= reconfig_cnt_ff + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // pin outputs
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            io_hiz             <= 1'b1;
            io_pullup_en       <= 1'b0;
            user_reset_n       <= 1'b0;
            user_mode          <= 1'b0;
            chain_enable_out_n <= 1'b1;
        end else begin
            // i/o and user reset only released once initialisation is over; chain out already low in init
            io_hiz       <= (nxt_state != ST_USER);
            io_pullup_en <= (nxt_state != ST_USER) & ~pullup_dis_s;
            user_reset_n <= (nxt_state == ST_USER);
            user_mode    <= (nxt_state == ST_USER);
            chain_enable_out_n <= ~((nxt_state == ST_INIT) ||
                                    (nxt_state == ST_USER));
        end
    end

    // ----------------------------------------------------------------
    // pll reload, enabled only while the sequencer holds user mode
    // ----------------------------------------------------------------
    wire pll_pins  = ctrl_ff[`CMS_CTRL_PLL_PINS];
    wire pll_shift = user_mode & (pll_pins ? sclk_rise : pll_shift_int);
    wire pll_load  = user_mode & (pll_pins ? ld_rise : pll_load_int);

    // only the pll settings change here; the rest stays in user mode
    cms_pll_shift u_pll (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .shift_en     (pll_shift),
        .sdata        (pll_pins ? pll_sd_s : pll_sdata_int),
        .load         (pll_load),
        .pll_mult_ff  (pll_mult),
        .pll_div_ff   (pll_div),
        .pll_delay_ff (pll_delay)
    );

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    reg        aw_got_ff;
    reg        w_got_ff;
    reg [1:0]  aw_idx_ff;
    reg        aw_bad_ff;
    reg [31:0] wdata_ff;
    reg [3:0]  wstrb_ff;
    reg [31:0] rd_word;
    reg        rd_bad;

    assign s_axi_awready = ~aw_got_ff & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_got_ff & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire aw_bad_in = |s_axi_awaddr[`CMS_ADDR_HI:`CMS_ADDR_LO+2];
    wire ar_bad_in = |s_axi_araddr[`CMS_ADDR_HI:`CMS_ADDR_LO+2];
    wire wr_go     = aw_got_ff & w_got_ff & ~s_axi_bvalid;
    wire [1:0] ar_idx = s_axi_araddr[`CMS_ADDR_LO+1:`CMS_ADDR_LO];

    always @* begin
        rd_word = 32'h0000_0000;
        rd_bad  = ar_bad_in;
        case (ar_idx)
            `CMS_REG_CTRL:    rd_word = ctrl_ff;
            `CMS_REG_CFG_LEN: rd_word = {16'h0000, cfg_len_ff};
            `CMS_REG_STATUS:  rd_word = {16'h0000, reconfig_cnt_ff,
                                         1'b0, por_sel_ff, ~user_mode,
                                         user_mode, 1'b0, state_ff};
            `CMS_REG_PLL:     rd_word = {8'h00, pll_delay, pll_div,
                                         pll_mult};
            default:          rd_word = 32'h0000_0000;
        endcase
        if (ar_bad_in) begin
            rd_word = 32'h0000_0000;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff    <= 1'b0;
            w_got_ff     <= 1'b0;
            aw_idx_ff    <= 2'h0;
            aw_bad_ff    <= 1'b0;
            wdata_ff     <= 32'h0000_0000;
            wstrb_ff     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CMS_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `CMS_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            ctrl_ff      <= `CMS_CTRL_RST;
            cfg_len_ff   <= `CMS_LEN_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                aw_idx_ff <= s_axi_awaddr[`CMS_ADDR_LO+1:`CMS_ADDR_LO];
                aw_bad_ff <= aw_bad_in;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_ff    <= 1'b0;
                w_got_ff     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_bad_ff || aw_idx_ff == `CMS_REG_STATUS
                                 || aw_idx_ff == `CMS_REG_PLL) ?
                                `CMS_RESP_SLVERR : `CMS_RESP_OKAY;
                if (!aw_bad_ff && aw_idx_ff == `CMS_REG_CTRL) begin
                    if (wstrb_ff[0]) ctrl_ff[7:0] <= wdata_ff[7:0];
                end
                if (!aw_bad_ff && aw_idx_ff == `CMS_REG_CFG_LEN) begin
                    if (wstrb_ff[0]) cfg_len_ff[7:0]  <= wdata_ff[7:0];
                    if (wstrb_ff[1]) cfg_len_ff[15:8] <= wdata_ff[15:8];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_bad ? `CMS_RESP_SLVERR : `CMS_RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // cms_top
